/* File: tb/core_sequencer_model.sv */
// sequencer stand-in: op codes to core pulses, plus reset feedback
module core_sequencer_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fault_reset,
  input wire logic [2:0] op,
  output logic rst,
  output logic stack_overflow,
  output logic stack_underflow,
  output logic interrupt_vector,
  output logic fast_call,
  output logic fast_return,
  output logic return_from_interrupt_instr,
  output logic add_w_to_file_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [7:0] hot = 8'h01 << op;
  assign {add_w_to_file_instr, return_from_interrupt_instr, fast_return, fast_call,
    interrupt_vector, stack_underflow, stack_overflow} = hot[7:1];
  // flopped so the flag is seen before the reset lands
  always_ff @(posedge clk) rst <= sys_rst | fault_reset;
endmodule : core_sequencer_model

/* File: tb/stack_fault_unit_sva.sv */
// assertions for the stack fault and shadow register block
module stack_fault_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] config_word_4l,
  input wire logic stack_overflow,
  input wire logic clear_full,
  input wire logic [7:0] working_register,
  input wire logic interrupt_vector,
  input wire logic fast_return,
  input wire logic return_from_interrupt_instr,
  input wire logic fast_option,
  input wire logic stack_full_flag,
  input wire logic fault_reset,
  input wire logic restore_valid,
  input wire logic [7:0] restore_work
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || por);
  a_reset_on:
    assert property (stack_overflow && config_word_4l[0] |=> ##1 fault_reset) else $error("no reset");
  a_reset_off:
    assert property (fault_reset |-> $past(config_word_4l[0], 2)) else $error("stray reset");
  a_full_set:
    assert property (disable iff (por) stack_overflow |=> stack_full_flag) else $error("no flag");
  a_flag_sticky:
    assert property (disable iff (por) stack_full_flag && !clear_full |=> stack_full_flag)
    else $error("flag lost");
  a_flag_clear:
    assert property (clear_full && !stack_overflow |=> !stack_full_flag) else $error("no clear");
  a_fast_restore:
    assert property ((fast_return || return_from_interrupt_instr) && fast_option |=> restore_valid)
    else $error("no restore");
  a_plain_return:
    assert property (restore_valid |-> $past(fast_option)) else $error("plain restore");
  a_shadow_data:
    assert property (interrupt_vector ##1 !interrupt_vector ##1
      (return_from_interrupt_instr && fast_option) |=> restore_work == $past(working_register, 3))
    else $error("bad shadow");
  c_fault: cover property (fault_reset);
  c_restore: cover property (restore_valid);
  c_clear: cover property (clear_full && stack_full_flag);
endmodule : stack_fault_sva
bind stack_fault_unit stack_fault_sva chk (.*);

/* File: tb/stack_fault_unit_test.sv */
// self-checking bench for the stack fault and shadow register block
module stack_fault_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, por, fast_option, clear_full, clear_underflow, ptr_write, table_read;
  logic table_write_req, latch_write, rst, stack_overflow, stack_underflow, interrupt_vector;
  logic fast_call, fast_return, return_from_interrupt_instr, add_w_to_file_instr, pcl_write;
  logic stack_full_flag, stack_underflow_flag, fault_reset, restore_valid, table_write;
  logic [2:0] op;
  logic [3:0] bank_select_register, restore_bank;
  logic [7:0] config_word_4l, status_reg, working_register, prog_byte, latch_data;
  logic [7:0] restore_status, restore_work, table_latch, table_write_data;
  logic [20:0] pc_now, pc_target;
  logic [21:0] ptr_data, table_pointer, table_write_addr;
  int failures, samples_checked, cycles;
  stack_fault_unit DUT (.*);
  core_sequencer_model seq (.*);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 1000)
    begin
      failures++;
      results();
    end
  end
  task automatic results;
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("ERROR %0t bad output", $time);
    end
  endtask : chk
  task automatic step(input logic [2:0] o, input logic [7:0] w, input logic f);
    @(posedge clk);
    op <= o;
    {status_reg, working_register, bank_select_register, fast_option} <= {w, w, w[3:0], f};
    @(posedge clk);
    op <= 3'h0;
    @(negedge clk);
  endtask : step
  task automatic fault_case(input logic on);
    @(posedge clk);
    config_word_4l <= {7'h00, on};
    step(3'h1, 8'h00, 1'b0);
    chk(stack_full_flag === 1'b1);
    @(negedge clk) chk(fault_reset === on);
    repeat (3) @(negedge clk);
    chk(stack_full_flag === 1'b1);
    @(posedge clk) clear_full <= 1'b1;
    @(posedge clk) clear_full <= 1'b0;
    @(negedge clk) chk(stack_full_flag === 1'b0);
    step(3'h2, 8'h00, 1'b0);
    chk(stack_underflow_flag === 1'b1);
    @(posedge clk) clear_underflow <= 1'b1;
    @(posedge clk) clear_underflow <= 1'b0;
    @(negedge clk) chk(stack_underflow_flag === 1'b0);
    step(3'h2, 8'h00, 1'b0);
    chk(stack_underflow_flag === 1'b1);
    repeat (3) @(posedge clk);
    por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    @(negedge clk) chk(stack_underflow_flag === 1'b0);
  endtask : fault_case
  task automatic shadow_case;
    step(3'h5, 8'h99, 1'b1);
    chk(restore_valid === 1'b1 && restore_work === 8'h00);
    step(3'h3, 8'h5a, 1'b0);
    step(3'h6, 8'h11, 1'b0);
    chk(restore_valid === 1'b0);
    step(3'h6, 8'h22, 1'b1);
    chk(restore_status === 8'h5a && restore_bank === 4'ha);
    step(3'h3, 8'h33, 1'b0);
    step(3'h3, 8'h44, 1'b0);
    step(3'h6, 8'h55, 1'b1);
    chk(restore_work === 8'h44);
    step(3'h4, 8'h66, 1'b1);
    step(3'h4, 8'h77, 1'b0);
    step(3'h5, 8'h88, 1'b1);
    chk(restore_valid === 1'b1 && restore_work === 8'h66);
  endtask : shadow_case
  task automatic table_case;
    @(posedge clk);
    {ptr_write, latch_write, ptr_data, latch_data, pc_now} <= {2'h3, 22'h2abcde, 8'hd2, 21'h1fc};
    @(posedge clk) {ptr_write, latch_write, table_write_req} <= 3'h1;
    @(posedge clk) {table_write_req, table_read, prog_byte} <= {2'h1, 8'h3c};
    @(negedge clk) chk(table_write_addr === 22'h2abcde && table_write_data === 8'hd2);
    chk(table_write === 1'b1);
    @(posedge clk) table_read <= 1'b0;
    @(negedge clk) chk(table_latch === 8'h3c && table_pointer === 22'h2abcde);
    step(3'h7, 8'h04, 1'b0);
    chk(pcl_write === 1'b1 && pc_target === 21'h000100);
  endtask : table_case
  initial
  begin
    {op, config_word_4l, prog_byte, latch_data, pc_now, ptr_data} = '0;
    {fast_option, clear_full, clear_underflow, ptr_write, table_read} = '0;
    {table_write_req, latch_write, status_reg, working_register, bank_select_register} = '0;
    {sys_rst, por} = 2'h3;
    repeat (8) @(posedge clk);
    {sys_rst, por} <= 2'h0;
    fault_case(1'b1);
    fault_case(1'b0);
    shadow_case();
    table_case();
    results();
  end
endmodule : stack_fault_unit_test

/* File: verilog/stack_fault_cfg.svh */
// constants and rule summary for the stack fault and shadow register block
//
// Operation
// - fault reset option comes from configuration word 4L
// - option on: set flag, then force reset
// - option off: set flag, no reset
// - flags sticky until software clear or power-on
// - one hidden shadow entry per saved register
// - every interrupt vector captures the three registers
// - fast interrupt return restores, plain return does not
// - high-priority vector overwrites low-priority shadow values
// - fast call saves registers into shadow
// - fast return restores registers from shadow
// - table access moves one byte via latch
`ifndef STACK_FAULT_CFG_SVH
`define STACK_FAULT_CFG_SVH
`define CFG4L_FAULT_RESET_BIT 0
`define STATUS_RESET 8'h00
`define WORK_RESET 8'h00
`define BANK_RESET 4'h0
`define PTR_RESET 22'h000000
`define LATCH_RESET 8'h00
`define PC_RESET 21'h000000
`endif

/* File: verilog/stack_fault_pkg.sv */
// types shared by the stack fault and shadow register block
package stack_fault_pkg;
  typedef enum logic [1:0] {
    fault_idle,
    fault_reset_pending
  } fault_state_t;

  typedef struct packed {
    fault_state_t fstate;
    logic stack_full_flag;
    logic stack_underflow_flag;
    logic fault_reset;
    logic [7:0] shadow_status;
    logic [7:0] shadow_work;
    logic [3:0] shadow_bank;
    logic restore_valid;
    logic [7:0] restore_status;
    logic [7:0] restore_work;
    logic [3:0] restore_bank;
    logic pcl_write;
    logic [20:0] pc_target;
    logic [21:0] table_pointer;
    logic [7:0] table_latch;
    logic table_write;
    logic [21:0] table_write_addr;
    logic [7:0] table_write_data;
  } core_state_t;
endpackage : stack_fault_pkg

/* File: verilog/stack_fault_unit.sv */
// stack fault flags, fast shadow registers, computed jump and table access
`include "stack_fault_cfg.svh"
module stack_fault_unit
  import stack_fault_pkg::*;
(
  // -----------------------------------------------------------
  // clock, resets and configuration
  // -----------------------------------------------------------
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] config_word_4l,
  // -----------------------------------------------------------
  // stack events and software clears
  // -----------------------------------------------------------
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic clear_full,
  input wire logic clear_underflow,
  // -----------------------------------------------------------
  // live core registers
  // -----------------------------------------------------------
  input wire logic [7:0] status_reg,
  input wire logic [7:0] working_register,
  input wire logic [3:0] bank_select_register,
  // -----------------------------------------------------------
  // vectoring and fast call or return
  // -----------------------------------------------------------
  input wire logic interrupt_vector,
  input wire logic fast_call,
  input wire logic return_from_interrupt_instr,
  input wire logic fast_return,
  input wire logic fast_option,
  // -----------------------------------------------------------
  // computed jump
  // -----------------------------------------------------------
  input wire logic add_w_to_file_instr,
  input wire logic [20:0] pc_now,
  // -----------------------------------------------------------
  // table access
  // -----------------------------------------------------------
  input wire logic ptr_write,
  input wire logic [21:0] ptr_data,
  input wire logic table_read,
  input wire logic table_write_req,
  input wire logic [7:0] prog_byte,
  input wire logic latch_write,
  input wire logic [7:0] latch_data,
  // -----------------------------------------------------------
  // stack fault outputs
  // -----------------------------------------------------------
  output logic stack_full_flag,
  output logic stack_underflow_flag,
  output logic fault_reset,
  // -----------------------------------------------------------
  // fast return outputs
  // -----------------------------------------------------------
  output logic restore_valid,
  output logic [7:0] restore_status,
  output logic [7:0] restore_work,
  output logic [3:0] restore_bank,
  // -----------------------------------------------------------
  // jump and table outputs
  // -----------------------------------------------------------
  output logic pcl_write,
  output logic [20:0] pc_target,
  output logic [21:0] table_pointer,
  output logic [7:0] table_latch,
  output logic table_write,
  output logic [21:0] table_write_addr,
  output logic [7:0] table_write_data
);

  core_state_t cur;
  core_state_t next_cur;
  logic fault_reset_enable;
  logic fault_event;
  logic capture_now;
  logic restore_now;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  function automatic logic [20:0] computed_target(
    input logic [20:0] pc,
    input logic [7:0] w
  );
    // only the low byte is replaced by the sum; carry is not propagated
    computed_target = {pc[20:8], 8'(pc[7:0] + w)};
  endfunction : computed_target

  function automatic logic fault_strobe(
    input logic overflow,
    input logic underflow
  );
    // either direction of stack fault counts alike
    fault_strobe = overflow || underflow;
  endfunction : fault_strobe

  function automatic logic fault_reset_armed(
    input logic event_seen,
    input logic enable
  );
    // the option bit is a level, read on the fault edge itself
    fault_reset_armed = event_seen && enable;
  endfunction : fault_reset_armed

  function automatic logic capture_strobe(
    input logic vector,
    input logic call,
    input logic fast
  );
    // every vector captures; a call only with the fast option
    capture_strobe = vector || (call && fast);
  endfunction : capture_strobe

  function automatic logic restore_strobe(
    input logic intr_return,
    input logic sub_return,
    input logic fast
  );
    // a plain return leaves the core registers alone
    restore_strobe = (intr_return || sub_return) && fast;
  endfunction : restore_strobe

  assign fault_reset_enable = config_word_4l[`CFG4L_FAULT_RESET_BIT];

  // -----------------------------------------------------------
  // event decode
  // -----------------------------------------------------------
  // decoded once so every section sees the same strobe
  assign fault_event = fault_strobe(stack_overflow, stack_underflow);
  assign capture_now = capture_strobe(interrupt_vector, fast_call, fast_option);
  assign restore_now = restore_strobe(return_from_interrupt_instr, fast_return, fast_option);

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.restore_valid = 1'b0;
    next_cur.pcl_write = 1'b0;
    next_cur.table_write = 1'b0;
    next_cur.fault_reset = 1'b0;

    // -------------------------------------------------------
    // sticky flags
    // -------------------------------------------------------
    // set beats clear so no fault event is lost
    if (clear_full)
    begin
      next_cur.stack_full_flag = 1'b0;
    end
    if (clear_underflow)
    begin
      next_cur.stack_underflow_flag = 1'b0;
    end
    if (stack_overflow)
    begin
      next_cur.stack_full_flag = 1'b1;
    end
    if (stack_underflow)
    begin
      next_cur.stack_underflow_flag = 1'b1;
    end

    // -------------------------------------------------------
    // fault reset sequencing
    // -------------------------------------------------------
    // flag is visible one cycle before the reset pulse
    unique case (cur.fstate)
      fault_idle:
      begin
        if (fault_reset_armed(fault_event, fault_reset_enable))
        begin
          next_cur.fstate = fault_reset_pending;
        end
      end
      fault_reset_pending:
      begin
        next_cur.fault_reset = 1'b1;
        next_cur.fstate = fault_idle;
      end
      default:
      begin
        // illegal codes fall back to idle
        next_cur.fstate = fault_idle;
      end
    endcase

    // -------------------------------------------------------
    // shadow capture and restore
    // -------------------------------------------------------
    // a later vector simply overwrites, high priority included
    if (capture_now)
    begin
      next_cur.shadow_status = status_reg;
      next_cur.shadow_work = working_register;
      next_cur.shadow_bank = bank_select_register;
    end

    // no validity tracking: whatever was captured last comes back
    if (restore_now)
    begin
      next_cur.restore_valid = 1'b1;
      next_cur.restore_status = cur.shadow_status;
      next_cur.restore_work = cur.shadow_work;
      next_cur.restore_bank = cur.shadow_bank;
    end

    // -------------------------------------------------------
    // computed jump
    // -------------------------------------------------------
    if (add_w_to_file_instr)
    begin
      // odd offsets land mid-instruction; software keeps them even
      next_cur.pcl_write = 1'b1;
      next_cur.pc_target = computed_target(pc_now, working_register);
    end

    // -------------------------------------------------------
    // table access
    // -------------------------------------------------------
    // a read wins when both transfers arrive together
    if (ptr_write)
    begin
      next_cur.table_pointer = ptr_data;
    end
    if (latch_write)
    begin
      next_cur.table_latch = latch_data;
    end
    if (table_read)
    begin
      next_cur.table_latch = prog_byte;
    end
    else if (table_write_req)
    begin
      next_cur.table_write = 1'b1;
      next_cur.table_write_addr = cur.table_pointer;
      next_cur.table_write_data = cur.table_latch;
    end
  end

  // -----------------------------------------------------------
  // state register
  // -----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || por)
    begin
      cur <= '0;
      cur.fstate <= fault_idle;
      cur.shadow_status <= `STATUS_RESET;
      cur.shadow_work <= `WORK_RESET;
      cur.shadow_bank <= `BANK_RESET;
      cur.table_pointer <= `PTR_RESET;
      cur.table_latch <= `LATCH_RESET;
      cur.pc_target <= `PC_RESET;
      // only power-on clears the sticky flags
      if (!por)
      begin
        cur.stack_full_flag <= next_cur.stack_full_flag;
        cur.stack_underflow_flag <= next_cur.stack_underflow_flag;
      end
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // -----------------------------------------------------------
  // fault outputs
  // -----------------------------------------------------------
  assign stack_full_flag = cur.stack_full_flag;
  assign stack_underflow_flag = cur.stack_underflow_flag;
  assign fault_reset = cur.fault_reset;

  // -----------------------------------------------------------
  // restore outputs
  // -----------------------------------------------------------
  assign restore_valid = cur.restore_valid;
  assign restore_status = cur.restore_status;
  assign restore_work = cur.restore_work;
  assign restore_bank = cur.restore_bank;

  // -----------------------------------------------------------
  // jump and table outputs
  // -----------------------------------------------------------
  assign pcl_write = cur.pcl_write;
  assign pc_target = cur.pc_target;
  assign table_pointer = cur.table_pointer;
  assign table_latch = cur.table_latch;
  assign table_write = cur.table_write;
  assign table_write_addr = cur.table_write_addr;
  assign table_write_data = cur.table_write_data;

endmodule : stack_fault_unit
